//--- rtl/sdb_bank_dev.sv
// Banked memory end: per-bank state, cross-bank interruption and data beat timing
`timescale 1ns/100ps
`default_nettype none
module sdb_bank_dev
	import sdb_pkg::*;
#(
	parameter int BURST = BURST_LEN,
	parameter int CL = CAS_LATENCY
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	sdb_if.dev LINK,
	output logic RD_VALID_O,
	output logic [BANK_W-1:0] RD_BANK_O,
	output logic WR_TAKEN_O,
	output logic [BANK_W-1:0] WR_BANK_O,
	output logic ALL_IDLE_O,
	output logic CMD_ERROR_O
);
	if (BURST < 1 || BURST > 255 || CL < 2 || CL > 8) begin : g_bad_burst
		$error("sdb_bank_dev: unsupported burst length or CAS latency");
	end
	if (PRECHARGE_CYC > 255 || WRITE_RECOVERY_CYC > 255 || ROW_TO_COLUMN_CYC > 255) begin : g_bad_timing
		$error("sdb_bank_dev: timing count exceeds timer width");
	end

	localparam logic [TIMER_W-1:0] T_RP = TIMER_W'(PRECHARGE_CYC);
	localparam logic [TIMER_W-1:0] T_WR = TIMER_W'(WRITE_RECOVERY_CYC);
	localparam logic [TIMER_W-1:0] T_RCD = TIMER_W'(ROW_TO_COLUMN_CYC);
	localparam logic [TIMER_W-1:0] T_REF = TIMER_W'(REFRESH_BUSY_CYC);
	localparam logic [TIMER_W-1:0] T_MRD = TIMER_W'(MODE_BUSY_CYC);
	localparam logic [TIMER_W-1:0] BEATS_AFTER_FIRST = TIMER_W'(BURST - 1);

	sdb_bank_st_t state [NUM_BANKS];
	sdb_bank_st_t next_state [NUM_BANKS];
	logic [TIMER_W-1:0] timer [NUM_BANKS];
	logic [TIMER_W-1:0] next_timer [NUM_BANKS];
	logic [TIMER_W-1:0] beats [NUM_BANKS];
	logic [TIMER_W-1:0] next_beats [NUM_BANKS];
	logic [NUM_BANKS-1:0] rd_beat;
	logic [NUM_BANKS-1:0] wr_beat;
	logic [NUM_BANKS-1:0] bank_err;
	logic [NUM_BANKS-1:0] bank_idle;

	// Chip-wide busy period for refresh and mode load
	logic [TIMER_W-1:0] busy;
	logic [TIMER_W-1:0] next_busy;
	logic global_err;
	logic all_idle_now;
	logic cmd_live;

	assign all_idle_now = (&bank_idle) && (busy == '0);
	// Commands are ignored while the chip-wide busy period runs
	assign cmd_live = (busy == '0);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
			logic hit;
			logic other_burst;
			logic timer_done;

			assign hit = cmd_live && (LINK.ba == BANK_W'(gi));
			assign other_burst = cmd_live && (LINK.ba != BANK_W'(gi))
				&& (LINK.cmd == CMD_READ || LINK.cmd == CMD_WRITE);
			assign timer_done = (timer[gi] <= TIMER_W'(1));
			assign bank_idle[gi] = (state[gi] == BK_IDLE);

			always_comb begin
				next_state[gi] = state[gi];
				next_timer[gi] = (timer[gi] != '0) ? timer[gi] - TIMER_W'(1) : '0;
				next_beats[gi] = beats[gi];
				rd_beat[gi] = 1'b0;
				wr_beat[gi] = 1'b0;
				bank_err[gi] = 1'b0;
				unique case (state[gi])
					BK_IDLE: begin
						if (hit && LINK.cmd == CMD_ACTIVE) begin
							next_state[gi] = BK_ACTIVATING;
							next_timer[gi] = T_RCD;
						end else if (hit && (LINK.cmd == CMD_READ || LINK.cmd == CMD_WRITE
							|| LINK.cmd == CMD_BURST_STOP)) begin
							bank_err[gi] = 1'b1;
						end
					end
					BK_ACTIVATING: begin
						if (timer_done)
							next_state[gi] = BK_ACTIVE;
						if (hit && LINK.cmd != CMD_NOP)
							bank_err[gi] = 1'b1;
					end
					BK_ACTIVE, BK_READ, BK_WRITE: begin
						if (hit && LINK.cmd == CMD_READ) begin
							next_state[gi] = LINK.ap ? BK_READ_AP : BK_READ;
							next_beats[gi] = BEATS_AFTER_FIRST;
						end else if (hit && LINK.cmd == CMD_WRITE) begin
							next_state[gi] = LINK.ap ? BK_WRITE_AP : BK_WRITE;
							next_beats[gi] = BEATS_AFTER_FIRST;
						end else if ((hit && LINK.cmd == CMD_PRECHARGE)
							|| (cmd_live && LINK.cmd == CMD_PRECHARGE_ALL)) begin
							next_state[gi] = BK_PRECHARGING;
							next_timer[gi] = T_RP;
						end else if (hit && LINK.cmd == CMD_BURST_STOP) begin
							if (state[gi] == BK_ACTIVE)
								bank_err[gi] = 1'b1;
							else
								next_state[gi] = BK_ACTIVE;
						end else if (hit && LINK.cmd == CMD_ACTIVE) begin
							bank_err[gi] = 1'b1;
						end else if (state[gi] != BK_ACTIVE) begin
							if (other_burst) begin
								next_state[gi] = BK_ACTIVE;
							end else if (beats[gi] != '0) begin
								// Other-bank activates and precharges leave this burst alone
								next_beats[gi] = beats[gi] - TIMER_W'(1);
								rd_beat[gi] = (state[gi] == BK_READ);
								wr_beat[gi] = (state[gi] == BK_WRITE);
							end else begin
								next_state[gi] = BK_ACTIVE;
							end
						end
					end
					BK_READ_AP: begin
						if (other_burst || beats[gi] == '0) begin
							next_state[gi] = BK_PRECHARGING;
							next_timer[gi] = T_RP;
						end else begin
							next_beats[gi] = beats[gi] - TIMER_W'(1);
							rd_beat[gi] = 1'b1;
						end
						if (hit && LINK.cmd != CMD_NOP)
							bank_err[gi] = 1'b1;
					end
					BK_WRITE_AP: begin
						if (other_burst || beats[gi] == '0) begin
							// Recovery counts from the interrupting command
							next_state[gi] = BK_WRITE_RECOVERY;
							next_timer[gi] = T_WR;
						end else begin
							next_beats[gi] = beats[gi] - TIMER_W'(1);
							wr_beat[gi] = 1'b1;
						end
						if (hit && LINK.cmd != CMD_NOP)
							bank_err[gi] = 1'b1;
					end
					BK_WRITE_RECOVERY: begin
						if (timer_done) begin
							next_state[gi] = BK_PRECHARGING;
							next_timer[gi] = T_RP;
						end
						if (hit && LINK.cmd != CMD_NOP)
							bank_err[gi] = 1'b1;
					end
					BK_PRECHARGING: begin
						if (timer_done)
							next_state[gi] = BK_IDLE;
						if (hit && LINK.cmd != CMD_NOP)
							bank_err[gi] = 1'b1;
					end
				endcase
			end

			always_ff @(posedge CLK_I or posedge RST_I) begin
				if (RST_I) begin
					state[gi] <= BK_IDLE;
					timer[gi] <= '0;
					beats[gi] <= '0;
				end else begin
					state[gi] <= next_state[gi];
					timer[gi] <= next_timer[gi];
					beats[gi] <= next_beats[gi];
				end
			end

			assign LINK.bank_state[gi] = state[gi];
		end
	endgenerate

	// Chip-wide commands need every bank idle
	always_comb begin
		next_busy = (busy != '0) ? busy - TIMER_W'(1) : '0;
		global_err = 1'b0;
		if (cmd_live && (LINK.cmd == CMD_AUTO_REFRESH || LINK.cmd == CMD_SELF_REFRESH
			|| LINK.cmd == CMD_MODE_LOAD)) begin
			if (!all_idle_now)
				global_err = 1'b1;
			else if (LINK.cmd == CMD_AUTO_REFRESH)
				next_busy = T_REF;
			else if (LINK.cmd == CMD_MODE_LOAD)
				next_busy = T_MRD;
		end
		if (!cmd_live && LINK.cmd != CMD_NOP)
			global_err = 1'b1;
	end

	// Data beats: first beat belongs to the registering command, later ones to the bank
	logic rd_now;
	logic wr_now;
	logic [BANK_W-1:0] rd_bank_now;
	logic [BANK_W-1:0] wr_bank_now;
	logic [CL-2:0] pipe_v;
	logic [CL-2:0] next_pipe_v;
	logic [BANK_W-1:0] pipe_b [CL-1];
	logic [BANK_W-1:0] next_pipe_b [CL-1];
	logic next_rd_valid;
	logic next_wr_taken;
	logic [BANK_W-1:0] next_wr_bank;
	logic next_error;

	always_comb begin
		rd_now = 1'b0;
		wr_now = 1'b0;
		rd_bank_now = '0;
		wr_bank_now = '0;
		for (int b = 0; b < NUM_BANKS; b++) begin
			if (rd_beat[b]) begin
				rd_now = 1'b1;
				rd_bank_now = BANK_W'(b);
			end
			if (wr_beat[b]) begin
				wr_now = 1'b1;
				wr_bank_now = BANK_W'(b);
			end
		end
		// A newly registered burst takes the bus in its own registration cycle
		if (cmd_live && LINK.cmd == CMD_READ && !bank_err[LINK.ba]) begin
			rd_now = 1'b1;
			rd_bank_now = LINK.ba;
		end
		if (cmd_live && LINK.cmd == CMD_WRITE && !bank_err[LINK.ba]) begin
			wr_now = 1'b1;
			wr_bank_now = LINK.ba;
		end
		next_pipe_v[0] = rd_now;
		next_pipe_b[0] = rd_bank_now;
		for (int k = 1; k < CL - 1; k++) begin
			next_pipe_v[k] = pipe_v[k-1];
			next_pipe_b[k] = pipe_b[k-1];
		end
		next_rd_valid = pipe_v[CL-2];
		// A write ends read data at once; the controller masks the bus beforehand
		if (wr_now && cmd_live && LINK.cmd == CMD_WRITE) begin
			next_pipe_v = '0;
			next_rd_valid = 1'b0;
		end
		next_wr_taken = wr_now;
		next_wr_bank = wr_bank_now;
		next_error = global_err || (|bank_err);
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			busy <= '0;
			pipe_v <= '0;
			for (int k = 0; k < CL - 1; k++)
				pipe_b[k] <= '0;
			RD_VALID_O <= 1'b0;
			RD_BANK_O <= '0;
			WR_TAKEN_O <= 1'b0;
			WR_BANK_O <= '0;
			ALL_IDLE_O <= 1'b1;
			CMD_ERROR_O <= 1'b0;
		end else begin
			busy <= next_busy;
			pipe_v <= next_pipe_v;
			for (int k = 0; k < CL - 1; k++)
				pipe_b[k] <= next_pipe_b[k];
			RD_VALID_O <= next_rd_valid;
			RD_BANK_O <= pipe_b[CL-2];
			WR_TAKEN_O <= next_wr_taken;
			WR_BANK_O <= next_wr_bank;
			ALL_IDLE_O <= all_idle_now;
			CMD_ERROR_O <= next_error;
		end
	end
endmodule : sdb_bank_dev
`default_nettype wire

//--- rtl/sdb_ctl.sv
// Controller end: checks requests against bank states and times the data mask
`timescale 1ns/100ps
`default_nettype none
module sdb_ctl
	import sdb_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_I,
	sdb_if.ctl LINK,
	input wire logic REQ_VALID_I,
	input wire sdb_cmd_t REQ_CMD_I,
	input wire logic [BANK_W-1:0] REQ_BANK_I,
	input wire logic REQ_AP_I,
	output logic REQ_READY_O,
	output logic REQ_REJECT_O
);
	typedef enum logic [1:0] {C_WAIT_REQ, C_MASK, C_SETTLE} sdb_ctl_st_t;

	sdb_ctl_st_t st;
	sdb_ctl_st_t next_st;
	sdb_cmd_t held_cmd;
	sdb_cmd_t next_held_cmd;
	logic [BANK_W-1:0] held_ba;
	logic [BANK_W-1:0] next_held_ba;
	logic held_ap;
	logic next_held_ap;
	logic [1:0] mask_cnt;
	logic [1:0] next_mask_cnt;
	sdb_cmd_t next_cmd;
	logic [BANK_W-1:0] next_ba;
	logic next_ap;
	logic next_dqm;
	logic next_ready;
	logic next_reject;

	logic all_idle;
	logic read_live;
	logic read_ap_live;
	sdb_bank_st_t tgt;
	logic legal;

	always_comb begin
		all_idle = 1'b1;
		read_live = 1'b0;
		read_ap_live = 1'b0;
		for (int b = 0; b < NUM_BANKS; b++) begin
			if (LINK.bank_state[b] != BK_IDLE)
				all_idle = 1'b0;
			// Only reads in other banks share the data bus with the new write
			if (LINK.bank_state[b] == BK_READ && BANK_W'(b) != REQ_BANK_I)
				read_live = 1'b1;
			if (LINK.bank_state[b] == BK_READ_AP && BANK_W'(b) != REQ_BANK_I)
				read_ap_live = 1'b1;
		end
		tgt = LINK.bank_state[REQ_BANK_I];
		unique case (REQ_CMD_I)
			CMD_NOP: legal = 1'b1;
			CMD_ACTIVE: legal = (tgt == BK_IDLE);
			CMD_READ, CMD_WRITE: legal = (tgt == BK_ACTIVE || tgt == BK_READ || tgt == BK_WRITE);
			CMD_PRECHARGE: legal = (tgt == BK_IDLE || tgt == BK_ACTIVE || tgt == BK_READ || tgt == BK_WRITE);
			CMD_BURST_STOP: legal = (tgt == BK_READ || tgt == BK_WRITE);
			CMD_PRECHARGE_ALL: begin
				legal = 1'b1;
				for (int b = 0; b < NUM_BANKS; b++)
					if (LINK.bank_state[b] == BK_ACTIVATING || LINK.bank_state[b] == BK_READ_AP
						|| LINK.bank_state[b] == BK_WRITE_AP || LINK.bank_state[b] == BK_WRITE_RECOVERY)
						legal = 1'b0;
			end
			CMD_AUTO_REFRESH, CMD_SELF_REFRESH, CMD_MODE_LOAD: legal = all_idle;
			default: legal = 1'b0;
		endcase
	end

	always_comb begin
		next_st = st;
		next_held_cmd = held_cmd;
		next_held_ba = held_ba;
		next_held_ap = held_ap;
		next_mask_cnt = (mask_cnt != '0) ? mask_cnt - 2'd1 : '0;
		next_cmd = CMD_NOP;
		next_ba = LINK.ba;
		next_ap = 1'b0;
		next_dqm = 1'b0;
		next_ready = 1'b0;
		next_reject = 1'b0;
		unique case (st)
			C_WAIT_REQ: begin
				next_ready = 1'b1;
				if (REQ_VALID_I && REQ_READY_O) begin
					next_ready = 1'b0;
					if (!legal) begin
						next_reject = 1'b1;
						next_ready = 1'b1;
					end else if (REQ_CMD_I == CMD_WRITE && (read_live || read_ap_live)) begin
						// Mask the bus early so read data and write data never collide
						next_st = C_MASK;
						next_dqm = 1'b1;
						next_mask_cnt = read_ap_live ? 2'd1 : 2'd0;
						next_held_cmd = REQ_CMD_I;
						next_held_ba = REQ_BANK_I;
						next_held_ap = REQ_AP_I;
					end else begin
						next_st = C_SETTLE;
						next_cmd = REQ_CMD_I;
						next_ba = REQ_BANK_I;
						next_ap = REQ_AP_I && (REQ_CMD_I == CMD_READ || REQ_CMD_I == CMD_WRITE);
					end
				end
			end
			C_MASK: begin
				next_dqm = 1'b1;
				if (mask_cnt == '0) begin
					next_st = C_SETTLE;
					next_cmd = held_cmd;
					next_ba = held_ba;
					next_ap = held_ap;
				end
			end
			C_SETTLE: begin
				// Wait one clock so the bank states reflect the command just sent
				next_st = C_WAIT_REQ;
				next_ready = 1'b1;
			end
			default: next_st = C_WAIT_REQ;
		endcase
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			st <= C_WAIT_REQ;
			held_cmd <= CMD_NOP;
			held_ba <= '0;
			held_ap <= 1'b0;
			mask_cnt <= '0;
			LINK.cmd <= CMD_NOP;
			LINK.ba <= '0;
			LINK.ap <= 1'b0;
			LINK.dqm <= 1'b0;
			REQ_READY_O <= 1'b0;
			REQ_REJECT_O <= 1'b0;
		end else begin
			st <= next_st;
			held_cmd <= next_held_cmd;
			held_ba <= next_held_ba;
			held_ap <= next_held_ap;
			mask_cnt <= next_mask_cnt;
			LINK.cmd <= next_cmd;
			LINK.ba <= next_ba;
			LINK.ap <= next_ap;
			LINK.dqm <= next_dqm;
			REQ_READY_O <= next_ready;
			REQ_REJECT_O <= next_reject;
		end
	end
endmodule : sdb_ctl
`default_nettype wire

//--- rtl/sdb_if.sv
// Command link between the memory controller and the banked memory
`timescale 1ns/100ps
`default_nettype none
interface sdb_if;
	import sdb_pkg::*;
	sdb_cmd_t cmd;
	logic [BANK_W-1:0] ba;
	logic ap;
	logic dqm;
	sdb_bank_st_t [NUM_BANKS-1:0] bank_state;
	modport dev (input cmd, input ba, input ap, input dqm, output bank_state);
	modport ctl (output cmd, output ba, output ap, output dqm, input bank_state);
endinterface : sdb_if
`default_nettype wire

//--- rtl/sdb_pkg.sv
// Package of commands, bank states and timing counts for the bank interleave pair
package sdb_pkg;
	localparam int NUM_BANKS = 4;
	localparam int BANK_W = 2;
	localparam int TIMER_W = 8;
	localparam int BURST_LEN = 4;
	localparam int CAS_LATENCY = 3;
	localparam int CLK_PERIOD_NS = 5;
	localparam int PRECHARGE_TIME_NS = 18;
	localparam int WRITE_RECOVERY_TIME_NS = 12;
	localparam int ROW_TO_COLUMN_DELAY_NS = 18;
	localparam int REFRESH_BUSY_CYC = 8;
	localparam int MODE_BUSY_CYC = 2;
	// Least times round up to whole clocks; a zero time gives zero clocks
	localparam int PRECHARGE_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_RECOVERY_CYC = (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ROW_TO_COLUMN_CYC = (ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		CMD_NOP,
		CMD_ACTIVE,
		CMD_READ,
		CMD_WRITE,
		CMD_PRECHARGE,
		CMD_PRECHARGE_ALL,
		CMD_BURST_STOP,
		CMD_AUTO_REFRESH,
		CMD_SELF_REFRESH,
		CMD_MODE_LOAD
	} sdb_cmd_t;

	typedef enum logic [3:0] {
		BK_IDLE,
		BK_ACTIVATING,
		BK_ACTIVE,
		BK_READ,
		BK_WRITE,
		BK_READ_AP,
		BK_WRITE_AP,
		BK_WRITE_RECOVERY,
		BK_PRECHARGING
	} sdb_bank_st_t;
endpackage : sdb_pkg

//--- tb/sdb_bank_interleave_rules_tb.sv
// Bench: controller and memory joined on one link, driven through the request port
`timescale 1ns/100ps
`default_nettype none
module sdb_bank_interleave_rules_tb;
	import sdb_pkg::*;
	// Longer burst so that every interruption lands mid-burst
	localparam int BURST_T = 8;
	logic clk;
	logic rst;
	logic req_valid;
	sdb_cmd_t req_cmd;
	logic [BANK_W-1:0] req_bank;
	logic req_ap;
	logic req_ready;
	logic req_reject;
	logic rd_valid;
	logic wr_taken;
	logic all_idle;
	logic cmd_error;
	logic [BANK_W-1:0] rd_bank;
	logic [BANK_W-1:0] wr_bank;
	logic dqm_seen;
	logic rej_seen;
	int miscompares;
	int checks;
	int err_cnt;
	int rd_cnt [NUM_BANKS];
	int wr_cnt [NUM_BANKS];
	sdb_if sdb_if_i();
	sdb_bank_dev #(.BURST(BURST_T)) sdb_bank_dev_i (.CLK_I(clk), .RST_I(rst), .LINK(sdb_if_i),
		.RD_VALID_O(rd_valid), .RD_BANK_O(rd_bank), .WR_TAKEN_O(wr_taken), .WR_BANK_O(wr_bank),
		.ALL_IDLE_O(all_idle), .CMD_ERROR_O(cmd_error));
	sdb_ctl sdb_ctl_i (.CLK_I(clk), .RST_I(rst), .LINK(sdb_if_i), .REQ_VALID_I(req_valid),
		.REQ_CMD_I(req_cmd), .REQ_BANK_I(req_bank), .REQ_AP_I(req_ap), .REQ_READY_O(req_ready),
		.REQ_REJECT_O(req_reject));
	sdb_link_assertions sdb_link_assertions_i (.CLK_I(clk), .RST_I(rst), .cmd(sdb_if_i.cmd),
		.ba(sdb_if_i.ba), .ap(sdb_if_i.ap), .dqm(sdb_if_i.dqm), .bank_state(sdb_if_i.bank_state));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Pulses are counted mid-cycle, where the flops have settled
	always @(negedge clk) begin
		if (rd_valid === 1'b1) rd_cnt[rd_bank]++;
		if (wr_taken === 1'b1) wr_cnt[wr_bank]++;
		if (cmd_error === 1'b1) err_cnt++;
		if (req_reject === 1'b1) rej_seen = 1'b1;
		if (sdb_if_i.dqm === 1'b1) dqm_seen = 1'b1;
	end
	task automatic stop_test();
		if (miscompares == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic clear();
		foreach (rd_cnt[i]) begin
			rd_cnt[i] = 0;
			wr_cnt[i] = 0;
		end
		err_cnt = 0;
		dqm_seen = 1'b0;
	endtask : clear
	task automatic issue(input sdb_cmd_t c, input int b, input logic a);
		int n;
		n = 0;
		rej_seen = 1'b0;
		req_valid = 1'b1;
		req_cmd = c;
		req_bank = BANK_W'(b);
		req_ap = a;
		while (req_ready !== 1'b1 && n < 20) begin
			step(1);
			n++;
		end
		if (req_ready !== 1'b1) begin
			check("req_ready", 1, req_ready);
			stop_test();
		end
		step(1);
		req_valid = 1'b0;
	endtask : issue
	task automatic wait_st(input int b, input sdb_bank_st_t st, input int max);
		int n;
		n = 0;
		while (sdb_if_i.bank_state[b] !== st && n < max) begin
			step(1);
			n++;
		end
		check("bank_state", st, sdb_if_i.bank_state[b]);
		if (sdb_if_i.bank_state[b] !== st) stop_test();
	endtask : wait_st
	task automatic sc_reset();
		check("all_idle", 1, all_idle);
		check("req_ready", 1, req_ready);
		for (int b = 0; b < NUM_BANKS; b++) check("bank_state", BK_IDLE, sdb_if_i.bank_state[b]);
	endtask : sc_reset
	task automatic sc_open();
		for (int b = 0; b < 3; b++) begin
			issue(CMD_ACTIVE, b, 1'b0);
			wait_st(b, BK_ACTIVATING, 2);
			wait_st(b, BK_ACTIVE, 6);
		end
		check("bank_state", BK_IDLE, sdb_if_i.bank_state[3]);
	endtask : sc_open
	task automatic sc_read_read();
		clear();
		issue(CMD_READ, 0, 1'b0);
		issue(CMD_READ, 1, 1'b0);
		// The second read registers one clock after the request is taken
		step(1);
		check("bank_state", BK_ACTIVE, sdb_if_i.bank_state[0]);
		step(16);
		check("rd_beats", 2, rd_cnt[0]);
		check("rd_beats", BURST_T, rd_cnt[1]);
		check("cmd_error", 0, err_cnt);
	endtask : sc_read_read
	task automatic sc_burst_stop();
		issue(CMD_READ, 0, 1'b0);
		issue(CMD_BURST_STOP, 2, 1'b0);
		step(2);
		check("reject", 1, rej_seen);
		check("bank_state", BK_READ, sdb_if_i.bank_state[0]);
		issue(CMD_BURST_STOP, 0, 1'b0);
		wait_st(0, BK_ACTIVE, 3);
	endtask : sc_burst_stop
	task automatic sc_write_read();
		clear();
		issue(CMD_WRITE, 0, 1'b1);
		issue(CMD_READ, 1, 1'b0);
		wait_st(0, BK_WRITE_RECOVERY, 2);
		wait_st(0, BK_PRECHARGING, 4);
		wait_st(0, BK_IDLE, 5);
		step(12);
		check("wr_beats", 2, wr_cnt[0]);
		check("rd_beats", BURST_T, rd_cnt[1]);
	endtask : sc_write_read
	task automatic sc_read_write();
		clear();
		issue(CMD_READ, 1, 1'b1);
		issue(CMD_WRITE, 2, 1'b0);
		wait_st(1, BK_PRECHARGING, 4);
		wait_st(1, BK_IDLE, 6);
		check("dqm_seen", 1, dqm_seen);
		step(12);
		check("wr_beats", BURST_T, wr_cnt[2]);
		check("rd_cut", 1, rd_cnt[1] < BURST_T);
	endtask : sc_read_write
	task automatic sc_refresh();
		sdb_cmd_t cl [3];
		int n;
		cl = '{CMD_AUTO_REFRESH, CMD_MODE_LOAD, CMD_SELF_REFRESH};
		clear();
		issue(CMD_AUTO_REFRESH, 0, 1'b0);
		step(2);
		check("reject", 1, rej_seen);
		issue(CMD_PRECHARGE, 2, 1'b0);
		wait_st(2, BK_IDLE, 8);
		foreach (cl[i]) begin
			issue(cl[i], 0, 1'b0);
			step(2);
			check("reject", 0, rej_seen);
			n = 0;
			while (all_idle !== 1'b1 && n < 20) begin
				step(1);
				n++;
			end
			check("all_idle", 1, all_idle);
			if (all_idle !== 1'b1) stop_test();
		end
		check("cmd_error", 0, err_cnt);
	endtask : sc_refresh
	task automatic sc_plain_cut();
		clear();
		issue(CMD_READ, 0, 1'b0);
		issue(CMD_WRITE, 1, 1'b0);
		step(2);
		check("bank_state", BK_ACTIVE, sdb_if_i.bank_state[0]);
		check("dqm_seen", 1, dqm_seen);
		issue(CMD_WRITE, 2, 1'b0);
		step(1);
		check("bank_state", BK_ACTIVE, sdb_if_i.bank_state[1]);
		step(12);
		check("rd_cut", 1, rd_cnt[0] < BURST_T);
		check("wr_beats", 2, wr_cnt[1]);
		check("wr_beats", BURST_T, wr_cnt[2]);
		check("cmd_error", 0, err_cnt);
	endtask : sc_plain_cut
	task automatic sc_ap_cut();
		clear();
		issue(CMD_READ, 0, 1'b1);
		issue(CMD_READ, 1, 1'b0);
		wait_st(0, BK_PRECHARGING, 2);
		issue(CMD_WRITE, 2, 1'b1);
		issue(CMD_WRITE, 1, 1'b0);
		wait_st(2, BK_WRITE_RECOVERY, 2);
		check("wr_beats", 2, wr_cnt[2]);
		check("rd_beats", 2, rd_cnt[0]);
		wait_st(2, BK_PRECHARGING, 4);
		wait_st(2, BK_IDLE, 5);
		wait_st(0, BK_IDLE, 1);
		check("cmd_error", 0, err_cnt);
	endtask : sc_ap_cut
	initial begin
		miscompares = 0;
		checks = 0;
		rst = 1'b1;
		req_valid = 1'b0;
		req_cmd = CMD_NOP;
		req_bank = '0;
		req_ap = 1'b0;
		rej_seen = 1'b0;
		clear();
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		step(2);
		sc_reset();
		sc_open();
		sc_read_read();
		sc_burst_stop();
		sc_write_read();
		sc_read_write();
		sc_refresh();
		sc_open();
		sc_plain_cut();
		sc_ap_cut();
		stop_test();
	end
endmodule : sdb_bank_interleave_rules_tb
`default_nettype wire

//--- tb/sdb_link_assertions.sv
// Checker on the link between controller and banked memory
`timescale 1ns/100ps
`default_nettype none
module sdb_link_assertions
	import sdb_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire sdb_cmd_t cmd,
	input wire logic [BANK_W-1:0] ba,
	input wire logic ap,
	input wire logic dqm,
	input wire sdb_bank_st_t [NUM_BANKS-1:0] bank_state
);
	logic [NUM_BANKS-1:0] rd_vec;
	logic [NUM_BANKS-1:0] rd_ap_vec;
	logic [NUM_BANKS-1:0] ba_hot;
	logic all_idle;
	logic access;
	always_comb begin
		rd_vec = '0;
		rd_ap_vec = '0;
		all_idle = 1'b1;
		for (int i = 0; i < NUM_BANKS; i++) begin
			rd_vec[i] = (bank_state[i] == BK_READ);
			rd_ap_vec[i] = (bank_state[i] == BK_READ_AP);
			all_idle = all_idle & (bank_state[i] == BK_IDLE);
		end
	end
	// Only reads in banks other than the write target collide with write data
	assign ba_hot = NUM_BANKS'(1) << ba;
	assign access = (cmd == CMD_READ) || (cmd == CMD_WRITE);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	cmd_spacing_a: assert property (cmd != CMD_NOP |=> cmd == CMD_NOP)
		else $error("commands issued back to back");
	ap_with_access_a: assert property (ap |-> access)
		else $error("auto precharge flag without read or write");
	refresh_all_idle_a: assert property (cmd inside {CMD_AUTO_REFRESH, CMD_SELF_REFRESH, CMD_MODE_LOAD} |-> all_idle)
		else $error("refresh or mode load with a bank busy");
	mask_before_write_a: assert property (
		(cmd == CMD_WRITE && ($past(rd_vec) & ~ba_hot) != '0) |-> $past(dqm))
		else $error("write after read without mask a clock before");
	mask_two_before_a: assert property (
		(cmd == CMD_WRITE && ($past(rd_ap_vec) & ~ba_hot) != '0) |-> $past(dqm) && $past(dqm, 2))
		else $error("write after auto precharge read without two clock mask");
	// Fixed bank index per block, since ba moves on with the next command
	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		activate_delay_a: assert property (
			(cmd == CMD_ACTIVE && ba == BANK_W'(b) && bank_state[b] == BK_IDLE) |=>
			(bank_state[b] == BK_ACTIVATING)[*3] ##[1:2] (bank_state[b] == BK_ACTIVE))
			else $error("activate did not settle to row active");
		plain_burst_end_a: assert property (
			(bank_state[b] inside {BK_READ, BK_WRITE} && access && ba != BANK_W'(b)) |=> bank_state[b] == BK_ACTIVE)
			else $error("plain burst not ended by other bank access");
		rdap_precharge_a: assert property (
			(bank_state[b] == BK_READ_AP && access && ba != BANK_W'(b)) |=> bank_state[b] == BK_PRECHARGING)
			else $error("interrupted read did not start precharge");
		wrap_recovery_a: assert property (
			(bank_state[b] == BK_WRITE_AP && access && ba != BANK_W'(b)) |=>
			(bank_state[b] == BK_WRITE_RECOVERY)[*2] ##[1:2] (bank_state[b] == BK_PRECHARGING))
			else $error("interrupted write skipped recovery");
		precharge_end_a: assert property (
			$rose(bank_state[b] == BK_PRECHARGING) |->
			(bank_state[b] == BK_PRECHARGING)[*3] ##[1:2] (bank_state[b] == BK_IDLE))
			else $error("precharge did not end in idle");
	end
endmodule : sdb_link_assertions
`default_nettype wire
